/* File: core/mrb_decoder.sv */
// Purpose: address remap, mode switching and boot scan of flash blocks
// Assumes: core requests and config strobes come from clk logic
// Notes:   one access per cycle, decode result registered
// Functional notes
// R1: fast peripherals shifted up by 0x100000
// R2: slow peripherals from 0xFFF7F600 never moved
// R3: fast peripherals each have a mapping register
// R4: slow bus runs at half clock rate
// R5: reset leaves rom mode, rom at zero
// R6: 8K rom aliased from 0 to 0x3FFFF
// R7: rom moves high first, then flash to zero
// R8: chosen block at zero, other at 0x8000
// R9: flash blocks serve accesses independently
// R10: checksums read from four fixed word locations
// R11: branch check before reading block checksums
// R12: hand over by mapping block at zero
// R13: command 0xF0 runs block 1, 0xF7 block 2
// R14: whole 64K usable as one program
// R15: mode changes apply between accesses only; a cfg return to rom mode applies at once, even mid-access
`timescale 1ns/1ns
module mrb_decoder
   import mrb_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       reqValid,
   input  wire logic [31:0]                reqAddr,
   input  wire logic                       cfgValid,
   input  wire logic                       cfgFlashMode,
   input  wire logic                       cfgBlk2AtZero,
   input  wire logic                       fastWr,
   input  wire logic [1:0]                 fastIdx,
   input  wire logic [31:0]                fastBase,
   input  wire logic                       cmdValid,
   input  wire logic [7:0]                 cmdCode,
   input  wire logic                       fl1Busy,
   input  wire logic                       fl2Busy,
   input  wire logic                       bootRdAck,
   input  wire logic [31:0]                bootRdData,
   output      mrb_pkg::mrb_tgt_e           accTgt,
   output      logic [31:0]                accOffset,
   output      logic [1:0]                 accFastIdx,
   output      logic                       accStall,
   output      logic                       ioClkEn,
   output      mrb_pkg::mrb_mode_e          memMode,
   output      logic                       blk2AtZero,
   output      logic                       bootRdReq,
   output      logic [31:0]                bootRdAddr,
   output      logic                       blk1Ok,
   output      logic                       blk2Ok,
   output      logic                       bootDone,
   output      logic [3:0][31:0]           sumWords
);
   typedef struct packed {
      mrb_mode_e       mode;
      logic            blk2;
      logic            toFlash;
      logic            ioEn;
      mrb_tgt_e        tgt;
      logic [31:0]     off;
      logic [1:0]      fIdx;
      logic            stall;
      logic [FAST_NUM-1:0][31:0] fBase;
      mrb_boot_e       bst;
      logic            done;
      logic [1:0]      sIdx;
      logic            rdReq;
      logic [31:0]     rdAddr;
      logic            ok1;
      logic            ok2;
      logic [3:0][31:0] sums;
   } mrb_state_s;

   logic [1:0]  rstSync;
   logic        rstN;
   mrb_state_s  st_q;
   mrb_state_s  st_d;
   mrb_tgt_e    memTgt;
   logic [31:0] memOff;
   logic [FAST_NUM-1:0] fastHit;
   logic [3:0][31:0] sumAddr;

   assign rstN    = rstSync[1];
   assign sumAddr = {SUM_TOP, SUM_B2B, SUM_B1A, SUM_B1B}; // R10

   // ==========================================================
   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end

   mrb_region uRegion (
      .addr       (reqAddr),
      .mode       (st_q.mode),
      .blk2AtZero (st_q.blk2),
      .tgt        (memTgt),
      .offset     (memOff)
   );

   // ==========================================================
   // fast peripheral windows, one mapping base each
   genvar gi;
   generate
      for (gi = 0; gi < FAST_NUM; gi++) begin : gFast
         assign fastHit[gi] = reqAddr >= st_q.fBase[gi] &&
                              reqAddr < st_q.fBase[gi] + FAST_SPAN; // R3
      end
   endgenerate

   // ==========================================================
   // next state
   always_comb begin
      st_d       = st_q;
      st_d.ioEn  = ~st_q.ioEn; // R4
      st_d.rdReq = 1'b0;
      // access decode, slow window checked first so it never moves
      st_d.stall = 1'b0;
      st_d.fIdx  = 2'b00;
      st_d.tgt   = TGT_NONE;
      st_d.off   = 32'h0000_0000;
      if (reqValid) begin
         if (reqAddr >= SLOW_BASE) begin
            st_d.tgt = TGT_SLOW; // R2
            st_d.off = reqAddr;
         end else if (|fastHit) begin
            st_d.tgt = TGT_FAST; // R1
            for (int i = 0; i < FAST_NUM; i++) begin
               if (fastHit[i]) begin
                  st_d.fIdx = 2'(i);
                  st_d.off  = reqAddr - st_q.fBase[i];
               end
            end
         end else begin
            st_d.tgt = memTgt;
            st_d.off = memOff;
            // a busy block stalls only its own accesses
            st_d.stall = (memTgt == TGT_FL1 && fl1Busy) ||
                         (memTgt == TGT_FL2 && fl2Busy); // R9
         end
      end
      if (fastWr) begin
         st_d.fBase[fastIdx] = fastBase; // R3
      end
      // flash entry steps wait for an idle cycle so no access is torn; a cfg return to rom mode applies at once
      if (!reqValid) begin // R15
         if (st_q.mode == MODE_ROMHI) begin
            st_d.mode    = MODE_FLASH; // R7
            st_d.toFlash = 1'b0;
         end else if (st_q.toFlash && st_q.mode == MODE_ROM) begin
            st_d.mode = MODE_ROMHI; // R7
         end
      end
      if (cmdValid && (cmdCode == CMD_RUN_B1 || cmdCode == CMD_RUN_B2)) begin
         st_d.blk2    = (cmdCode == CMD_RUN_B2); // R13 R12
         st_d.toFlash = 1'b1;
      end else if (cfgValid) begin
         st_d.blk2 = cfgBlk2AtZero; // R15
         if (cfgFlashMode) begin
            st_d.toFlash = (st_q.mode == MODE_ROM);
         end else begin
            st_d.mode    = MODE_ROM;
            st_d.toFlash = 1'b0;
         end
      end
      // boot scan of branch words, then checksum words
      unique case (st_q.bst)
         BS_BR1: begin
            st_d.rdReq  = !bootRdAck;
            st_d.rdAddr = FL_ROMMODE_BASE + BR1_ADDR;
            if (bootRdAck) begin
               st_d.ok1 = (bootRdData & BR_MASK) == BR_VAL; // R11
               st_d.bst = BS_BR2;
            end
         end
         BS_BR2: begin
            st_d.rdReq  = !bootRdAck;
            st_d.rdAddr = FL_ROMMODE_BASE + BR2_ADDR;
            if (bootRdAck) begin
               st_d.ok2  = (bootRdData & BR_MASK) == BR_VAL; // R11
               st_d.bst  = BS_SUM;
               st_d.sIdx = 2'd0;
            end
         end
         BS_SUM: begin
            // empty blocks are skipped; top word serves either block
            if ((st_q.sIdx < 2'd2 && !st_q.ok1) ||
                (st_q.sIdx == 2'd2 && !st_q.ok2) ||
                (st_q.sIdx == 2'd3 && !st_q.ok1 && !st_q.ok2)) begin
               st_d.sIdx = st_q.sIdx + 2'd1; // R11 R14
               st_d.bst  = (st_q.sIdx == 2'd3) ? BS_DONE : BS_SUM;
            end else begin
               st_d.rdReq  = !bootRdAck;
               st_d.rdAddr = FL_ROMMODE_BASE + sumAddr[st_q.sIdx]; // R10
               if (bootRdAck) begin
                  st_d.sums[st_q.sIdx] = bootRdData;
                  st_d.sIdx = st_q.sIdx + 2'd1;
                  st_d.bst  = (st_q.sIdx == 2'd3) ? BS_DONE : BS_SUM;
               end
            end
         end
         BS_DONE: begin
            st_d.rdReq = 1'b0;
         end
         default: begin
            st_d.bst = BS_DONE;
         end
      endcase
      st_d.done = (st_d.bst == BS_DONE); // flopped so the output is a flop
   end

   // ==========================================================
   // state register, reset leaves rom at zero
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         st_q      <= '0;
         st_q.mode <= MODE_ROM; // R5
         for (int i = 0; i < FAST_NUM; i++) begin
            st_q.fBase[i] <= FAST_OLD_BASE + FAST_SHIFT +
                             32'(i) * FAST_SPAN; // R1
         end
      end else begin
         st_q <= st_d;
      end
   end

   assign accTgt     = st_q.tgt;
   assign accOffset  = st_q.off;
   assign accFastIdx = st_q.fIdx;
   assign accStall   = st_q.stall;
   assign ioClkEn    = st_q.ioEn;
   assign memMode    = st_q.mode;
   assign blk2AtZero = st_q.blk2;
   assign bootRdReq  = st_q.rdReq;
   assign bootRdAddr = st_q.rdAddr;
   assign blk1Ok     = st_q.ok1;
   assign blk2Ok     = st_q.ok2;
   assign bootDone   = st_q.done;
   assign sumWords   = st_q.sums;

   // ==========================================================
   // checks
   sequence sFlashReq;
      st_q.mode == MODE_ROM && st_q.toFlash && !reqValid &&
      !cfgValid && !cmdValid;
   endsequence
   sequence sRomHi;
      st_q.mode == MODE_ROMHI;
   endsequence

   a_flash_order: assert property (@(posedge clk) disable iff (!rstN) // R7
      sFlashReq |=> sRomHi)
      else $error("flash entry skipped rom high step");
   a_romhi_short: assert property (@(posedge clk) disable iff (!rstN) // R7
      sRomHi ##0 (!reqValid && !cfgValid) |=> st_q.mode == MODE_FLASH)
      else $error("rom high step did not finish");
   a_rom_alias: assert property (@(posedge clk) disable iff (!rstN) // R6
      reqValid && st_q.mode == MODE_ROM && reqAddr <= ROM_ALIAS_TOP
      |=> accTgt == TGT_ROM && accOffset == $past(reqAddr) % ROM_SIZE)
      else $error("rom alias decode wrong");
   a_slow_fixed: assert property (@(posedge clk) disable iff (!rstN) // R2
      reqValid && reqAddr >= SLOW_BASE
      |=> accTgt == TGT_SLOW && accOffset == $past(reqAddr))
      else $error("slow peripheral moved");
   a_io_half: assert property (@(posedge clk) disable iff (!rstN) // R4
      ioClkEn |=> !ioClkEn ##1 ioClkEn)
      else $error("io enable not half rate");
   a_other_block: assert property (@(posedge clk) disable iff (!rstN) // R8
      reqValid && st_q.mode == MODE_FLASH && reqAddr >= FL_OTHER_BASE &&
      reqAddr < 2 * FL_BLK_SIZE
      |=> accTgt == ($past(st_q.blk2) ? TGT_FL1 : TGT_FL2))
      else $error("unselected block not at 0x8000");
   a_cmd_block: assert property (@(posedge clk) disable iff (!rstN) // R13
      cmdValid && cmdCode == CMD_RUN_B2 |=> blk2AtZero && st_q.toFlash)
      else $error("block 2 command not taken");
   a_busy_stall: assert property (@(posedge clk) disable iff (!rstN) // R9
      accTgt == TGT_FL1 && accStall |-> $past(fl1Busy))
      else $error("stall without busy block");
   a_fast_shift: assert property (@(posedge clk) disable iff (!rstN) // R1
      $rose(rstN) |-> st_q.fBase[0] == FAST_OLD_BASE + FAST_SHIFT)
      else $error("fast peripheral base not shifted");
   a_skip_empty: assert property (@(posedge clk) disable iff (!rstN) // R11
      st_q.bst == BS_SUM && st_q.sIdx == 2'd2 && !st_q.ok2
      |=> !bootRdReq && st_q.sIdx == 2'd3)
      else $error("checksum read from empty block");
endmodule

/* File: core/mrb_region.sv */
// Purpose: combinational memory region decode for rom, ram and flash
// Assumes: mode and block select are stable flop outputs
// Notes:   fast and slow peripherals are decoded by the parent
`timescale 1ns/1ns
module mrb_region
   import mrb_pkg::*;
(
   input  wire logic [31:0]       addr,
   input  wire mrb_pkg::mrb_mode_e mode,
   input  wire logic              blk2AtZero,
   output      mrb_pkg::mrb_tgt_e  tgt,
   output      logic [31:0]       offset
);
   logic [31:0] flBase;
   logic [31:0] flRel;

   // ==========================================================
   // decode: rom alias first, then rom high, flash, ram
   always_comb begin
      flBase = (mode == MODE_FLASH) ? 32'h0000_0000 : FL_ROMMODE_BASE;
      flRel  = addr - flBase;
      tgt    = TGT_NONE;
      offset = 32'h0000_0000;
      if (mode == MODE_ROM && addr <= ROM_ALIAS_TOP) begin
         tgt    = TGT_ROM; // R5 R6
         offset = addr & (ROM_SIZE - 32'h0000_0001);
      end else if (mode != MODE_ROM && addr >= ROM_HI_BASE &&
                   addr < ROM_HI_BASE + ROM_SIZE) begin
         tgt    = TGT_ROM; // R7
         offset = addr - ROM_HI_BASE;
      end else if (addr >= flBase && flRel < 2 * FL_BLK_SIZE) begin
         // chosen block low, the other always one block up
         if (flRel < FL_OTHER_BASE) begin
            tgt = blk2AtZero ? TGT_FL2 : TGT_FL1; // R8
         end else begin
            tgt = blk2AtZero ? TGT_FL1 : TGT_FL2; // R8
         end
         offset = flRel & (FL_BLK_SIZE - 32'h0000_0001);
      end else if (addr >= RAM_BASE && addr < RAM_BASE + RAM_SIZE) begin
         tgt    = TGT_RAM;
         offset = addr - RAM_BASE;
      end
   end
endmodule

/* File: dv/mrb_core_model.sv */
// Purpose: far side model answering boot scan reads from a flash image
// Assumes: one read outstanding at a time, driven from clk logic
// Notes:   answers promptly and slowly in turn; data is scrambled when idle
`timescale 1ns/1ns
module mrb_core_model (
   input  wire logic        clk,
   input  wire logic        rstN,
   input  wire logic        bootRdReq,
   input  wire logic [31:0] bootRdAddr,
   input  wire logic        blk2Full,
   output logic             bootRdAck,
   output logic [31:0]      bootRdData,
   output logic             badRead
);
   // ==========================================================
   // flash image
   logic [2:0] waitCnt;
   logic       slowTurn;

   // branch word opens block 1; block 2 is erased unless blk2Full
   function automatic logic [31:0] word(logic [31:0] a);
      if (a == 32'h0008_0000) return 32'hEA00_0010;
      if (a == 32'h0008_8000) return blk2Full ? 32'hEA00_0020 : 32'hFFFF_FFFF;
      return {a[15:0] ^ 16'hA5C3, a[15:0]};
   endfunction

   // ==========================================================
   // read answer, one pulse per read
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         bootRdAck  <= 1'b0;
         bootRdData <= 32'h5A5A_5A5A;
         waitCnt    <= 3'h0;
         slowTurn   <= 1'b0;
         badRead    <= 1'b0;
      end else if (bootRdAck) begin
         bootRdAck  <= 1'b0;
         bootRdData <= ~bootRdData; // released: never hold the old word
         waitCnt    <= 3'h0;
      end else if (bootRdReq) begin
         // an empty block must never have its checksum fetched
         if (!blk2Full && bootRdAddr == 32'h0008_87FC) badRead <= 1'b1;
         if (waitCnt == (slowTurn ? 3'h3 : 3'h0)) begin
            bootRdAck  <= 1'b1;
            bootRdData <= word(bootRdAddr);
            slowTurn   <= ~slowTurn;
         end else begin
            waitCnt <= waitCnt + 3'h1;
         end
      end
   end
endmodule

/* File: dv/mrb_decoder_tb.sv */
// Purpose: self-checking bench for the memory remap and boot select
// Assumes: inputs change 1 ns after the rising edge
// Notes:   boot scan runs twice, once per flash image
`timescale 1ns/1ns
module mrb_decoder_tb;
   import mrb_pkg::*;
   logic clk, rstN, reqValid, cfgValid, cfgFlashMode, cfgBlk2AtZero, fastWr;
   logic cmdValid, fl1Busy, fl2Busy, blk2Full, bootRdAck, accStall, ioClkEn;
   logic blk2AtZero, bootRdReq, blk1Ok, blk2Ok, bootDone, badRead;
   logic [1:0]       fastIdx, accFastIdx;
   logic [7:0]       cmdCode;
   logic [31:0]      reqAddr, fastBase, accOffset, bootRdAddr, bootRdData;
   logic [3:0][31:0] sumWords;
   mrb_tgt_e         accTgt;
   mrb_mode_e        memMode;
   int               errCount, numChecks, cycles;

   mrb_decoder u_dut (.clk(clk), .rst_n(rstN), .reqValid(reqValid),
      .reqAddr(reqAddr), .cfgValid(cfgValid), .cfgFlashMode(cfgFlashMode),
      .cfgBlk2AtZero(cfgBlk2AtZero), .fastWr(fastWr), .fastIdx(fastIdx),
      .fastBase(fastBase), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .fl1Busy(fl1Busy), .fl2Busy(fl2Busy), .bootRdAck(bootRdAck),
      .bootRdData(bootRdData), .accTgt(accTgt), .accOffset(accOffset),
      .accFastIdx(accFastIdx), .accStall(accStall), .ioClkEn(ioClkEn),
      .memMode(memMode), .blk2AtZero(blk2AtZero), .bootRdReq(bootRdReq),
      .bootRdAddr(bootRdAddr), .blk1Ok(blk1Ok), .blk2Ok(blk2Ok),
      .bootDone(bootDone), .sumWords(sumWords));
   mrb_core_model u_core (.clk(clk), .rstN(rstN), .bootRdReq(bootRdReq),
      .bootRdAddr(bootRdAddr), .blk2Full(blk2Full), .bootRdAck(bootRdAck),
      .bootRdData(bootRdData), .badRead(badRead));

   // ==========================================================
   // clock and hang guard, ceiling well above the under two hundred cycles used
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errCount++;
         giveVerdict();
      end
   end

   // ==========================================================
   // helpers
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         errCount++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] sw(logic [31:0] off);
      return {off[15:0] ^ 16'hA5C3, off[15:0]};
   endfunction
   // one access, result judged in the cycle it stands; reqValid stays up
   // so back to back calls never lower and raise it in one time step
   task automatic acc(logic [31:0] a, mrb_tgt_e t, logic [31:0] o, logic st);
      reqAddr  = a;
      reqValid = 1'b1;
      step();
      chk("accTgt", 32'(t), 32'(accTgt));
      chk("accOffset", o, accOffset);
      chk("accStall", 32'(st), 32'(accStall));
   endtask
   task automatic cfg(logic fm, logic b2);
      cfgFlashMode  = fm;
      cfgBlk2AtZero = b2;
      cfgValid      = 1'b1;
      step();
      cfgValid = 1'b0;
   endtask
   task automatic cmd(logic [7:0] c);
      cmdCode  = c;
      cmdValid = 1'b1;
      step();
      cmdValid = 1'b0;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_boot(logic full2);
      blk2Full = full2;
      rstN     = 1'b0;
      repeat (20) step();
      rstN = 1'b1;
      repeat (3) step(); // reset release passes two flops first
      chk("memMode", 32'(MODE_ROM), 32'(memMode));
      for (int i = 0; i < 300 && bootDone !== 1'b1; i++) step();
      chk("bootDone", 32'h1, 32'(bootDone));
      chk("blk1Ok", 32'h1, 32'(blk1Ok));
      chk("blk2Ok", 32'(full2), 32'(blk2Ok));
      chk("badRead", 32'h0, 32'(badRead));
      chk("sum0", sw(32'h7FC), sumWords[0]);
      chk("sum1", sw(32'h7FFC), sumWords[1]);
      chk("sum3", sw(32'hFFFC), sumWords[3]);
      if (full2) chk("sum2", sw(32'h87FC), sumWords[2]);
      acc(32'h0000_0004, TGT_ROM, 32'h4, 1'b0);
      $display("test boot done");
   endtask

   task automatic t_rom();
      acc(32'h0003_FFFC, TGT_ROM, 32'h1FFC, 1'b0);
      acc(32'h0001_2344, TGT_ROM, 32'h0344, 1'b0);
      acc(32'h0004_0000, TGT_NONE, 32'h0, 1'b0);
      acc(32'h0006_0010, TGT_RAM, 32'h10, 1'b0);
      acc(32'h0020_0810, TGT_FAST, 32'h10, 1'b0);
      chk("accFastIdx", 32'h2, 32'(accFastIdx));
      acc(32'h0010_0010, TGT_NONE, 32'h0, 1'b0);
      acc(SLOW_BASE, TGT_SLOW, SLOW_BASE, 1'b0);
      fastIdx  = 2'h1;
      fastBase = 32'h0030_0000;
      fastWr   = 1'b1;
      step();
      fastWr = 1'b0;
      acc(32'h0030_0008, TGT_FAST, 32'h8, 1'b0);
      chk("accFastIdx", 32'h1, 32'(accFastIdx));
      $display("test rom map done");
   endtask

   task automatic t_flash();
      reqAddr  = 32'h10;
      reqValid = 1'b1;
      cfg(1'b1, 1'b0);
      repeat (3) step();
      chk("memMode", 32'(MODE_ROM), 32'(memMode));
      reqValid = 1'b0;
      for (int i = 0; i < 4 && memMode === MODE_ROM; i++) step();
      chk("memMode", 32'(MODE_ROMHI), 32'(memMode));
      step();
      chk("memMode", 32'(MODE_FLASH), 32'(memMode));
      acc(32'h0000_0010, TGT_FL1, 32'h10, 1'b0);
      acc(32'h0000_8010, TGT_FL2, 32'h10, 1'b0);
      acc(32'h0002_0010, TGT_ROM, 32'h10, 1'b0);
      acc(32'h0000_FFFC, TGT_FL2, 32'h7FFC, 1'b0);
      cfg(1'b1, 1'b1);
      acc(32'h0000_0010, TGT_FL2, 32'h10, 1'b0);
      acc(32'h0000_8010, TGT_FL1, 32'h10, 1'b0);
      fl2Busy = 1'b1;
      acc(32'h0000_0020, TGT_FL2, 32'h20, 1'b1);
      acc(32'h0000_8020, TGT_FL1, 32'h20, 1'b0);
      fl2Busy = 1'b0;
      fl1Busy = 1'b1;
      acc(32'h0000_8020, TGT_FL1, 32'h20, 1'b1);
      acc(32'h0000_0020, TGT_FL2, 32'h20, 1'b0);
      fl1Busy = 1'b0;
      $display("test flash map done");
   endtask

   task automatic t_cmd();
      cfgBlk2AtZero = 1'b1; // a command beats a mapping write on one edge
      cfgFlashMode  = 1'b1;
      cfgValid      = 1'b1;
      cmd(CMD_RUN_B1);
      cfgValid = 1'b0;
      chk("blk2AtZero", 32'h0, 32'(blk2AtZero));
      step(); // let an edge pass before the strobe rises again
      cmd(8'h55);
      chk("blk2AtZero", 32'h0, 32'(blk2AtZero));
      step();
      cmd(CMD_RUN_B2);
      chk("blk2AtZero", 32'h1, 32'(blk2AtZero));
      acc(32'h0000_0010, TGT_FL2, 32'h10, 1'b0);
      cfg(1'b0, 1'b0);
      chk("memMode", 32'(MODE_ROM), 32'(memMode));
      acc(32'h0000_0000, TGT_ROM, 32'h0, 1'b0);
      reqValid = 1'b0;
      $display("test commands done");
   endtask

   task automatic t_ioclk();
      logic prev;
      prev = ioClkEn;
      for (int i = 0; i < 4; i++) begin
         step();
         chk("ioClkEn", 32'(!prev), 32'(ioClkEn));
         prev = ioClkEn;
      end
      $display("test slow bus enable done");
   endtask

   // ==========================================================
   // verdict, the single place the run ends
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {rstN, reqValid, cfgValid, cfgFlashMode, cfgBlk2AtZero} = '0;
      {fastWr, cmdValid, fl1Busy, fl2Busy, blk2Full}          = '0;
      {fastIdx, cmdCode, reqAddr, fastBase}                   = '0;
      {errCount, numChecks, cycles}                           = '0;
      t_boot(1'b0);
      t_rom();
      t_flash();
      t_cmd();
      t_ioclk();
      t_boot(1'b1); // second reset in mid-run, both blocks hold programs
      giveVerdict();
   end
endmodule

/* File: include/mrb_pkg.sv */
// Purpose: shared constants and types for the memory remap and boot select
// Assumes: 32-bit byte addresses, one processor clock
// Notes:   map bases not fixed by the mapping rules are plain defaults
package mrb_pkg;
   // ==========================================================
   // memory map
   localparam logic [31:0] ROM_SIZE       = 32'h0000_2000; // 8K image
   localparam logic [31:0] ROM_ALIAS_TOP  = 32'h0003_FFFF;
   localparam logic [31:0] ROM_HI_BASE    = 32'h0002_0000;
   localparam logic [31:0] FL_ROMMODE_BASE = 32'h0008_0000;
   localparam logic [31:0] FL_BLK_SIZE    = 32'h0000_8000; // 32K block
   localparam logic [31:0] FL_OTHER_BASE  = 32'h0000_8000;
   localparam logic [31:0] RAM_BASE       = 32'h0006_0000;
   localparam logic [31:0] RAM_SIZE       = 32'h0000_8000;
   localparam logic [31:0] FAST_SHIFT     = 32'h0010_0000;
   localparam logic [31:0] FAST_OLD_BASE  = 32'h0010_0000;
   localparam logic [31:0] FAST_SPAN      = 32'h0000_0400;
   localparam int          FAST_NUM       = 4;
   localparam logic [31:0] SLOW_BASE      = 32'hFFF7_F600;
   // ==========================================================
   // boot scan word locations, block 1 viewed at 0
   localparam logic [31:0] BR1_ADDR  = 32'h0000_0000;
   localparam logic [31:0] BR2_ADDR  = 32'h0000_8000;
   localparam logic [31:0] SUM_B1B   = 32'h0000_07FC;
   localparam logic [31:0] SUM_B1A   = 32'h0000_7FFC;
   localparam logic [31:0] SUM_B2B   = 32'h0000_87FC;
   localparam logic [31:0] SUM_TOP   = 32'h0000_FFFC;
   localparam logic [31:0] BR_MASK   = 32'h0F00_0000; // branch opcode field
   localparam logic [31:0] BR_VAL    = 32'h0A00_0000;
   // ==========================================================
   // boot commands
   localparam logic [7:0]  CMD_RUN_B1 = 8'hF0;
   localparam logic [7:0]  CMD_RUN_B2 = 8'hF7;

   typedef enum logic [1:0] {
      MODE_ROM   = 2'b00,
      MODE_ROMHI = 2'b01,
      MODE_FLASH = 2'b10
   } mrb_mode_e;

   typedef enum logic [2:0] {
      TGT_NONE = 3'b000,
      TGT_ROM  = 3'b001,
      TGT_RAM  = 3'b010,
      TGT_FL1  = 3'b011,
      TGT_FL2  = 3'b100,
      TGT_FAST = 3'b101,
      TGT_SLOW = 3'b110
   } mrb_tgt_e;

   typedef enum logic [2:0] {
      BS_BR1  = 3'b000,
      BS_BR2  = 3'b001,
      BS_SUM  = 3'b010,
      BS_DONE = 3'b011
   } mrb_boot_e;
endpackage
